// *** hdl/runtime_control_defs.vh ***
/*
 runtime control register block: offsets, reset value and map constants.
 assumes inclusion by bare name from the design file.
*/
`ifndef RUNTIME_CONTROL_DEFS_VH
`define RUNTIME_CONTROL_DEFS_VH
`define OFS_B_PIN_IN      8'h01
`define OFS_B_PIN_OUT     8'h05
`define OFS_B_DIR         8'h07
`define OFS_B_DRIVE       8'h09
`define OFS_B_IN_CELL     8'h0B
`define OFS_B_OE_STATE    8'h0D
`define OFS_C_PIN_IN      8'h10
`define OFS_D_PIN_IN      8'h11
`define OFS_C_PIN_OUT     8'h12
`define OFS_D_PIN_OUT     8'h13
`define OFS_C_DIR         8'h14
`define OFS_D_DIR         8'h15
`define OFS_C_DRIVE       8'h16
`define OFS_D_DRIVE       8'h17
`define OFS_C_IN_CELL     8'h18
`define OFS_C_OE_STATE    8'h1A
`define OFS_D_OE_STATE    8'h1B
`define OFS_CELL_FIRST    8'h20
`define OFS_CELL_SECOND   8'h21
`define OFS_MASK_FIRST    8'h22
`define OFS_MASK_SECOND   8'h23
`define OFS_PWR_FIRST     8'hB0
`define OFS_PWR_SECOND    8'hB4
`define OFS_MAIN_PROTECT  8'hC0
`define OFS_SEC_PROTECT   8'hC2
`define OFS_TEST_PORT_EN  8'hC7
`define OFS_PAGE          8'hE0
`define REG_RESET         8'h00
`define WINDOW_BASE       20'h02000
`define MAIN_BASE         20'h10000
`define MAIN_SECTOR_SIZE  20'h08000
`define SEC_BASE          20'h50000
`define SEC_SECTOR_SIZE   20'h02000
`endif

// *** hdl/runtime_control_register_block.v ***
/*
 runtime control register block: byte registers in a 256-location window
 reached by the host i/o strobe, plus flash sector select decode.
 assumes a synchronous host bus on clk_sys and external pins and
 protection status arriving asynchronously.
*/
`timescale 1ns/1ps
`include "runtime_control_defs.vh"
module runtime_control_register_block #(
    parameter ADDR_W     = 20,
    parameter MAIN_COUNT = 8,
    parameter SEC_COUNT  = 4
) (
    input  wire                  clk_sys,
    input  wire                  rst_n,
    input  wire [ADDR_W-1:0]     hostAddr,
    input  wire                  ioStrobe_n,
    input  wire                  bootStrobe_n,
    input  wire                  hostWrite,
    input  wire                  hostRead,
    input  wire [15:0]           hostWrData,
    output reg  [15:0]           hostRdData,
    input  wire [7:0]            portBIn,
    input  wire [7:0]            portCIn,
    input  wire [7:0]            portDIn,
    input  wire [7:0]            inputCellB,
    input  wire [7:0]            inputCellC,
    input  wire [7:0]            mainProtectIn,
    input  wire [7:0]            secProtectIn,
    output reg  [7:0]            portBOut,
    output reg  [7:0]            portCOut,
    output reg  [7:0]            portDOut,
    output reg  [7:0]            portBOe,
    output reg  [7:0]            portCOe,
    output reg  [7:0]            portDOe,
    output reg  [7:0]            portBDrive,
    output reg  [7:0]            portCDrive,
    output reg  [7:0]            portDDrive,
    output reg  [7:0]            outputCellFirst,
    output reg  [7:0]            outputCellSecond,
    output reg  [7:0]            powerFirst,
    output reg  [7:0]            powerSecond,
    output reg  [7:0]            testPortEnable,
    output reg  [7:0]            memoryPage,
    output reg  [MAIN_COUNT-1:0] mainSectorSelects,
    output reg  [SEC_COUNT-1:0]  secondarySectorSelects
);

    // storage registers
    reg [7:0] pinOutB;
    reg [7:0] pinOutC;
    reg [7:0] pinOutD;
    reg [7:0] dirB;
    reg [7:0] dirC;
    reg [7:0] dirD;
    reg [7:0] driveB;
    reg [7:0] driveC;
    reg [7:0] driveD;
    reg [7:0] cellFirst;
    reg [7:0] cellSecond;
    reg [7:0] maskFirst;
    reg [7:0] maskSecond;
    reg [7:0] pwrFirst;
    reg [7:0] pwrSecond;
    reg [7:0] testEn;
    reg [7:0] page;
    // two-stage synchronisers for outside inputs
    reg [55:0] syncA;
    reg [55:0] syncB;
    wire [7:0] liveB     = syncB[7:0];
    wire [7:0] liveC     = syncB[15:8];
    wire [7:0] liveD     = syncB[23:16];
    wire [7:0] cellInB   = syncB[31:24];
    wire [7:0] cellInC   = syncB[39:32];
    wire [7:0] mainProt  = syncB[47:40];
    wire [7:0] secProt   = syncB[55:48];

    // window hit: strobe qualified and base matches upper bits
    localparam [ADDR_W-1:0] WIN_BASE = `WINDOW_BASE;
    wire       inWindow = !ioStrobe_n &&
                          (hostAddr[ADDR_W-1:8] == WIN_BASE[ADDR_W-1:8]);
    wire [7:0] offset   = hostAddr[7:0];
    wire       doWrite  = inWindow && hostWrite;
    wire [7:0] wrByte   = hostWrData[7:0];

    reg  [7:0] next_rdByte;

    // masked cell merge: mask bit 1 keeps old value
    function [7:0] maskMerge;
        input [7:0] oldVal;
        input [7:0] newVal;
        input [7:0] mask;
        begin
            maskMerge = (oldVal & mask) | (newVal & ~mask);
        end
    endfunction

    // sector range check
    function inRange;
        input [ADDR_W-1:0] addr;
        input [ADDR_W-1:0] base;
        input [ADDR_W-1:0] size;
        begin
            inRange = (addr >= base) && (addr < base + size);
        end
    endfunction

    // synchroniser chain
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            syncA <= {7{`REG_RESET}};
            syncB <= {7{`REG_RESET}};
        end else begin
            syncA <= {secProtectIn, mainProtectIn, inputCellC, inputCellB,
                      portDIn, portCIn, portBIn};
            syncB <= syncA;
        end
    end

    // register writes; read-only and unused offsets ignored
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pinOutB    <= `REG_RESET;
            pinOutC    <= `REG_RESET;
            pinOutD    <= `REG_RESET;
            dirB       <= `REG_RESET;
            dirC       <= `REG_RESET;
            dirD       <= `REG_RESET;
            driveB     <= `REG_RESET;
            driveC     <= `REG_RESET;
            driveD     <= `REG_RESET;
            cellFirst  <= `REG_RESET;
            cellSecond <= `REG_RESET;
            maskFirst  <= `REG_RESET;
            maskSecond <= `REG_RESET;
            pwrFirst   <= `REG_RESET;
            pwrSecond  <= `REG_RESET;
            testEn     <= `REG_RESET;
            page       <= `REG_RESET;
        end else if (doWrite) begin
            case (offset)
                `OFS_B_PIN_OUT:    pinOutB <= wrByte;
                `OFS_C_PIN_OUT:    pinOutC <= wrByte;
                `OFS_D_PIN_OUT:    pinOutD <= wrByte;
                `OFS_B_DIR:        dirB <= wrByte;
                `OFS_C_DIR:        dirC <= wrByte;
                `OFS_D_DIR:        dirD <= wrByte;
                `OFS_B_DRIVE:      driveB <= wrByte;
                `OFS_C_DRIVE:      driveC <= wrByte;
                `OFS_D_DRIVE:      driveD <= wrByte;
                `OFS_CELL_FIRST:   cellFirst <= maskMerge(cellFirst, wrByte, maskFirst);
                `OFS_CELL_SECOND:  cellSecond <= maskMerge(cellSecond, wrByte, maskSecond);
                `OFS_MASK_FIRST:   maskFirst <= wrByte;
                `OFS_MASK_SECOND:  maskSecond <= wrByte;
                `OFS_PWR_FIRST:    pwrFirst <= wrByte;
                `OFS_PWR_SECOND:   pwrSecond <= wrByte;
                `OFS_TEST_PORT_EN: testEn <= wrByte;
                `OFS_PAGE:         page <= wrByte;
                default:           page <= page;
            endcase
        end
    end

    // read mux; unmapped offsets read zero
    always @* begin
        next_rdByte = 8'h00;
        case (offset)
            `OFS_B_PIN_IN:     next_rdByte = liveB;
            `OFS_C_PIN_IN:     next_rdByte = liveC;
            `OFS_D_PIN_IN:     next_rdByte = liveD;
            `OFS_B_PIN_OUT:    next_rdByte = pinOutB;
            `OFS_C_PIN_OUT:    next_rdByte = pinOutC;
            `OFS_D_PIN_OUT:    next_rdByte = pinOutD;
            `OFS_B_DIR:        next_rdByte = dirB;
            `OFS_C_DIR:        next_rdByte = dirC;
            `OFS_D_DIR:        next_rdByte = dirD;
            `OFS_B_DRIVE:      next_rdByte = driveB;
            `OFS_C_DRIVE:      next_rdByte = driveC;
            `OFS_D_DRIVE:      next_rdByte = driveD;
            `OFS_B_IN_CELL:    next_rdByte = cellInB;
            `OFS_C_IN_CELL:    next_rdByte = cellInC;
            `OFS_B_OE_STATE:   next_rdByte = dirB;
            `OFS_C_OE_STATE:   next_rdByte = dirC;
            `OFS_D_OE_STATE:   next_rdByte = dirD;
            `OFS_CELL_FIRST:   next_rdByte = cellFirst & ~maskFirst;
            `OFS_CELL_SECOND:  next_rdByte = cellSecond & ~maskSecond;
            `OFS_MASK_FIRST:   next_rdByte = maskFirst;
            `OFS_MASK_SECOND:  next_rdByte = maskSecond;
            `OFS_PWR_FIRST:    next_rdByte = pwrFirst;
            `OFS_PWR_SECOND:   next_rdByte = pwrSecond;
            `OFS_MAIN_PROTECT: next_rdByte = mainProt;
            `OFS_SEC_PROTECT:  next_rdByte = secProt;
            `OFS_TEST_PORT_EN: next_rdByte = testEn;
            `OFS_PAGE:         next_rdByte = page;
            default:           next_rdByte = 8'h00;
        endcase
    end

    // registered read data and mirrored outputs
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hostRdData       <= {2{`REG_RESET}};
            portBOut         <= `REG_RESET;
            portCOut         <= `REG_RESET;
            portDOut         <= `REG_RESET;
            portBOe          <= `REG_RESET;
            portCOe          <= `REG_RESET;
            portDOe          <= `REG_RESET;
            portBDrive       <= `REG_RESET;
            portCDrive       <= `REG_RESET;
            portDDrive       <= `REG_RESET;
            outputCellFirst  <= `REG_RESET;
            outputCellSecond <= `REG_RESET;
            powerFirst       <= `REG_RESET;
            powerSecond      <= `REG_RESET;
            testPortEnable   <= `REG_RESET;
            memoryPage       <= `REG_RESET;
        end else begin
            if (inWindow && hostRead) begin
                hostRdData <= {8'h00, next_rdByte};
            end
            portBOut         <= pinOutB;
            portCOut         <= pinOutC;
            portDOut         <= pinOutD;
            portBOe          <= dirB;
            portCOe          <= dirC;
            portDOe          <= dirD;
            portBDrive       <= driveB;
            portCDrive       <= driveC;
            portDDrive       <= driveD;
            outputCellFirst  <= cellFirst;
            outputCellSecond <= cellSecond;
            powerFirst       <= pwrFirst;
            powerSecond      <= pwrSecond;
            testPortEnable   <= testEn;
            memoryPage       <= page;
        end
    end

    // flash sector selects from boot strobe and address range
    integer i;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mainSectorSelects      <= {MAIN_COUNT{1'b0}};
            secondarySectorSelects <= {SEC_COUNT{1'b0}};
        end else begin
            for (i = 0; i < MAIN_COUNT; i = i + 1) begin
                mainSectorSelects[i] <= !bootStrobe_n &&
                    inRange(hostAddr, `MAIN_BASE + i[ADDR_W-1:0] * `MAIN_SECTOR_SIZE,
                            `MAIN_SECTOR_SIZE);
            end
            for (i = 0; i < SEC_COUNT; i = i + 1) begin
                secondarySectorSelects[i] <= !bootStrobe_n &&
                    inRange(hostAddr, `SEC_BASE + i[ADDR_W-1:0] * `SEC_SECTOR_SIZE,
                            `SEC_SECTOR_SIZE);
            end
        end
    end

endmodule // runtime_control_register_block

// *** verif/runtime_control_assertions.sv ***
/* assertion checker watching the register block ports.
   assumes it is bound to the block top and handed its parameters. */
`timescale 1ns/1ps
module runtime_control_assertions #(
    parameter ADDR_W     = 20,
    parameter MAIN_COUNT = 8,
    parameter SEC_COUNT  = 4
) (
    input logic                  clk_sys,
    input logic                  rst_n,
    input logic [ADDR_W-1:0]     hostAddr,
    input logic                  ioStrobe_n,
    input logic                  bootStrobe_n,
    input logic                  hostWrite,
    input logic                  hostRead,
    input logic [15:0]           hostWrData,
    input logic [15:0]           hostRdData,
    input logic [7:0]            portBOut,
    input logic [7:0]            portBOe,
    input logic [7:0]            powerFirst,
    input logic [7:0]            memoryPage,
    input logic [MAIN_COUNT-1:0] mainSectorSelects,
    input logic [SEC_COUNT-1:0]  secondarySectorSelects
);
    // window access decode
    wire       inWin = !ioStrobe_n && hostAddr[19:8] == 12'h020;
    wire       wrOn  = inWin && hostWrite;
    wire [7:0] ofs   = hostAddr[7:0];
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_upper_zero: assert property (hostRdData[15:8] == 8'h00)
        else $error("read data upper byte not zero");
    a_page_store: assert property (wrOn && ofs == 8'hE0 |-> ##2 memoryPage == $past(hostWrData[7:0], 2))
        else $error("page register output wrong after write");
    a_pin_drive: assert property (wrOn && ofs == 8'h05 |-> ##2 portBOut == $past(hostWrData[7:0], 2))
        else $error("port b output level wrong after write");
    a_dir_enable: assert property (wrOn && ofs == 8'h07 |-> ##2 portBOe == $past(hostWrData[7:0], 2))
        else $error("port b enables wrong after direction write");
    a_power_cause: assert property ($changed(powerFirst) |-> $past(wrOn && ofs == 8'hB0, 2))
        else $error("power register changed without a window write");
    a_main_first: assert property (!bootStrobe_n && hostAddr >= 20'h10000 && hostAddr <= 20'h17FFF |=> mainSectorSelects == 8'h01)
        else $error("first main sector select wrong");
    a_sec_first: assert property (!bootStrobe_n && hostAddr >= 20'h50000 && hostAddr <= 20'h51FFF |=> secondarySectorSelects == 4'h1)
        else $error("first secondary sector select wrong");
    a_strobe_idle: assert property (bootStrobe_n |=> mainSectorSelects == 8'h00 && secondarySectorSelects == 4'h0)
        else $error("sector select active without boot strobe");
    a_unmapped_zero: assert property (inWin && hostRead && ofs == 8'h40 |=> hostRdData == 16'h0000)
        else $error("unused location did not read zero");
endmodule // runtime_control_assertions
bind runtime_control_register_block runtime_control_assertions #(
    .ADDR_W(ADDR_W), .MAIN_COUNT(MAIN_COUNT), .SEC_COUNT(SEC_COUNT)
) u_chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .hostAddr(hostAddr), .ioStrobe_n(ioStrobe_n),
    .bootStrobe_n(bootStrobe_n), .hostWrite(hostWrite), .hostRead(hostRead),
    .hostWrData(hostWrData), .hostRdData(hostRdData), .portBOut(portBOut),
    .portBOe(portBOe), .powerFirst(powerFirst), .memoryPage(memoryPage),
    .mainSectorSelects(mainSectorSelects), .secondarySectorSelects(secondarySectorSelects)
);

// *** verif/host_bus_master.sv ***
/* host bus master model: byte accesses in i/o space and boot strobe cycles.
   assumes the block takes an access at the edge after it is driven. */
`timescale 1ns/1ps
module host_bus_master (
    input  logic        clk_sys,
    output logic [19:0] hostAddr,
    output logic        ioStrobe_n,
    output logic        bootStrobe_n,
    output logic        hostWrite,
    output logic        hostRead,
    output logic [15:0] hostWrData,
    input  logic [15:0] hostRdData
);
    // idle bus with both strobes released
    initial begin
        hostAddr = 20'h00000;
        ioStrobe_n = 1'b1;
        bootStrobe_n = 1'b1;
        hostWrite = 1'b0;
        hostRead = 1'b0;
        hostWrData = 16'h0000;
    end
    // kind 0 read, 1 write, 2 write with i/o strobe high, 3 boot strobe cycle
    task automatic access(input logic [19:0] a, input logic [7:0] d, input int k,
                          output logic [15:0] q);
        @(posedge clk_sys);
        hostAddr <= a;
        ioStrobe_n <= (k >= 2); // only i/o strobe qualified cycles reach the window
        bootStrobe_n <= (k != 3);
        hostWrite <= (k == 1 || k == 2);
        hostRead <= (k == 0);
        hostWrData <= {8'hFF, d}; // upper byte junk, only low byte counts
        @(posedge clk_sys);
        hostAddr <= ~a; // released bus shows no stale address
        ioStrobe_n <= 1'b1;
        bootStrobe_n <= 1'b1;
        hostWrite <= 1'b0;
        hostRead <= 1'b0;
        hostWrData <= {8'h00, ~d}; // unused locations are never written
        #1 q = hostRdData;
    endtask
endmodule // host_bus_master

// *** verif/test_runtime_control_register_block.sv ***
/* self-checking bench for the runtime control register block.
   assumes the host model drives the bus and the bench drives the pins. */
`timescale 1ns/1ps
module test_runtime_control_register_block;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic [19:0] hostAddr;
    logic        ioStrobe_n, bootStrobe_n, hostWrite, hostRead;
    logic [15:0] hostWrData, hostRdData, q;
    logic [7:0]  portBIn = 8'h00, inputCellB = 8'h00, mainProt = 8'h00, secProt = 8'h00;
    logic [7:0]  portCIn = 8'h00, portDIn = 8'h00, inputCellC = 8'h00;
    logic [7:0]  portBOut, portBOe, portBDrive, cellFirst, powerFirst, testEn, memoryPage;
    logic [7:0]  portCOut, portDOut, portCOe, portDOe, portCDrive, portDDrive;
    logic [7:0]  cellSecond, powerSecond;
    logic [7:0]  mainSel;
    logic [3:0]  secSel;
    int          badCount = 0, testsRun = 0, cycles = 0;
    logic [7:0]  allOfs [27] = '{8'h01, 8'h05, 8'h07, 8'h09, 8'h0B, 8'h0D, 8'h10, 8'h11,
        8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h1A, 8'h1B, 8'h20, 8'h21, 8'h22,
        8'h23, 8'hB0, 8'hB4, 8'hC0, 8'hC2, 8'hC7, 8'hE0};
    logic [7:0]  rwOfs [17] = '{8'h05, 8'h07, 8'h09, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16,
        8'h17, 8'h20, 8'h21, 8'h22, 8'h23, 8'hB0, 8'hB4, 8'hC7, 8'hE0};
    always #20 clk_sys = ~clk_sys;
    host_bus_master u_host (.clk_sys(clk_sys), .hostAddr(hostAddr), .ioStrobe_n(ioStrobe_n),
        .bootStrobe_n(bootStrobe_n), .hostWrite(hostWrite), .hostRead(hostRead),
        .hostWrData(hostWrData), .hostRdData(hostRdData));
    runtime_control_register_block u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .hostAddr(hostAddr), .ioStrobe_n(ioStrobe_n), .bootStrobe_n(bootStrobe_n),
        .hostWrite(hostWrite), .hostRead(hostRead), .hostWrData(hostWrData),
        .hostRdData(hostRdData), .portBIn(portBIn), .portCIn(portCIn), .portDIn(portDIn),
        .inputCellB(inputCellB), .inputCellC(inputCellC), .mainProtectIn(mainProt),
        .secProtectIn(secProt), .portBOut(portBOut), .portCOut(portCOut),
        .portDOut(portDOut), .portBOe(portBOe), .portCOe(portCOe), .portDOe(portDOe),
        .portBDrive(portBDrive), .portCDrive(portCDrive), .portDDrive(portDDrive),
        .outputCellFirst(cellFirst), .outputCellSecond(cellSecond),
        .powerFirst(powerFirst), .powerSecond(powerSecond), .testPortEnable(testEn),
        .memoryPage(memoryPage), .mainSectorSelects(mainSel), .secondarySectorSelects(secSel));
    function automatic logic [7:0] pat(int i);
        return 8'(i * 37 + 19);
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        testsRun++;
        if (got !== exp) begin
            badCount++;
            $display("[FAIL] %0t %s got %h expected %h", $time, m, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] o, input logic [7:0] d);
        u_host.access({12'h020, o}, d, 1, q);
    endtask
    task automatic rd(input logic [7:0] o, input logic [7:0] e);
        u_host.access({12'h020, o}, 8'h00, 0, q);
        chk(q, {8'h00, e}, "register read");
    endtask
    task automatic t_reset;
        foreach (allOfs[i]) rd(allOfs[i], 8'h00);
    endtask
    task automatic t_rw;
        foreach (rwOfs[i]) begin
            wr(rwOfs[i], pat(i));
            rd(rwOfs[i], pat(i));
        end
        chk(portBOut, pat(0), "pin level");
        chk(portBOe, pat(1), "pin enables");
        chk(portBDrive, pat(2), "drive select");
        chk(testEn, pat(15), "test port enable");
        chk(memoryPage, pat(16), "page output");
        chk({portCOut, portDOut}, {pat(3), pat(4)}, "port c d levels");
        chk({portCOe, portDOe}, {pat(5), pat(6)}, "port c d enables");
        chk({portCDrive, portDDrive}, {pat(7), pat(8)}, "port c d drive");
        chk({cellSecond, powerSecond}, {pat(10), pat(14)}, "bank and power");
    endtask
    task automatic t_ro;
        @(posedge clk_sys);
        portBIn <= 8'h5A;
        inputCellB <= 8'hC3;
        mainProt <= 8'h81;
        secProt <= 8'h0F;
        portCIn <= 8'hA6;
        portDIn <= 8'h3C;
        inputCellC <= 8'h69;
        repeat (3) @(posedge clk_sys);
        foreach (allOfs[i]) if (i < 6 && i != 1 && i != 2 && i != 3 || i == 6 || i == 7 ||
                                i >= 14 && i <= 16 || i == 23 || i == 24)
            wr(allOfs[i], 8'hFF);
        rd(8'h01, 8'h5A);
        rd(8'h10, 8'hA6);
        rd(8'h11, 8'h3C);
        rd(8'h0B, 8'hC3);
        rd(8'h18, 8'h69);
        rd(8'h0D, pat(1));
        rd(8'h1A, pat(5));
        rd(8'h1B, pat(6));
        rd(8'hC0, 8'h81);
        rd(8'hC2, 8'h0F);
    endtask
    task automatic t_mask;
        wr(8'h22, 8'h00);
        wr(8'h20, 8'hFF);
        wr(8'h22, 8'h0F);
        rd(8'h20, 8'hF0);
        wr(8'h20, 8'h00);
        rd(8'h20, 8'h00);
        chk(cellFirst, 8'h0F, "masked cell load");
        wr(8'h22, 8'h00);
        rd(8'h20, 8'h0F);
    endtask
    task automatic t_outside;
        u_host.access(20'h020B0, 8'h77, 2, q);
        u_host.access(20'h030B0, 8'h77, 1, q);
        rd(8'hB0, pat(13));
        chk(powerFirst, pat(13), "power output");
        rd(8'h40, 8'h00);
    endtask
    task automatic t_select;
        for (int n = 0; n < 8; n++) begin
            u_host.access(20'h10000 + n * 20'h08000 + 20'h07FFF, 8'h00, 3, q);
            chk(mainSel, 8'h01 << n, "main select");
        end
        for (int n = 0; n < 4; n++) begin
            u_host.access(20'h50000 + n * 20'h02000, 8'h00, 3, q);
            chk(secSel, 4'h1 << n, "secondary select");
        end
        u_host.access(20'h10000, 8'h00, 0, q);
        chk({mainSel, secSel}, 12'h000, "select without strobe");
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", testsRun, badCount);
        if (badCount == 0 && testsRun > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            badCount++;
            conclude();
        end
    end
    // main sequence
    initial begin
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset();
        t_rw();
        t_ro();
        t_mask();
        t_outside();
        t_select();
        conclude();
    end
endmodule // test_runtime_control_register_block
